//--- rtl/cprs_map.svh
`ifndef CPRS_MAP_SVH
`define CPRS_MAP_SVH

// minimum release delay in ns and derived cycle count at 100 MHz
`define CPRS_CLK_PERIOD_NS 10
`define CPRS_RELEASE_DELAY_NS 1000
`define CPRS_RELEASE_CYCLES ((`CPRS_RELEASE_DELAY_NS + `CPRS_CLK_PERIOD_NS - 1) / `CPRS_CLK_PERIOD_NS)
`define CPRS_CNT_W 16
`define CPRS_ADDR_W 20
`define CPRS_ADDR_ZERO 20'h00000
`define CPRS_CNT_ZERO 16'h0000
`define CPRS_CNT_ONE 16'h0001

`endif

//--- rtl/cprs_pkg.sv
package cprs_pkg;

    // supply monitor indications, already synchronous
    typedef struct packed {
        logic core_por_ok;
        logic io_level_ok;
        logic core_above_pd;
    } cprs_supply_t;

    // read-side control pins as seen by the device
    typedef struct packed {
        logic chip_enable_n;
        logic busy;
        logic clk_step;
    } cprs_ctrl_t;

    typedef enum logic [2:0] {
        CPRS_ST_HOLD = 3'h1,
        CPRS_ST_DELAY = 3'h2,
        CPRS_ST_RUN = 3'h4
    } cprs_state_t;

endpackage

//--- rtl/cprs_addr_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "cprs_map.svh"

module cprs_addr_counter (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // control
    input wire logic clear_i,
    input wire logic step_i,
    // state
    output logic [`CPRS_ADDR_W-1:0] addr_o,
    output logic at_end_o
);

    logic [`CPRS_ADDR_W-1:0] addr_ff;
    logic [`CPRS_ADDR_W-1:0] nxt_addr;

    // terminal count holds, clear wins over step
    always_comb begin
        nxt_addr = addr_ff;
        if (clear_i) begin
            nxt_addr = `CPRS_ADDR_ZERO;
        end else if (step_i && !(&addr_ff)) begin
            nxt_addr = addr_ff + {{(`CPRS_ADDR_W-1){1'b0}}, 1'b1};
        end
    end

    // address register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            addr_ff <= `CPRS_ADDR_ZERO;
        end else if (ce_i) begin
            addr_ff <= nxt_addr;
        end
    end

    assign addr_o = addr_ff;
    assign at_end_o = &addr_ff;

endmodule

`default_nettype wire

//--- rtl/cprs_sequencer.sv
// Overview of operation
// RULE_01: drive the shared reset line low throughout power-up.
// RULE_02: after supplies pass thresholds, wait the minimum release delay, then release.
// RULE_03: core supply below power-down threshold resets and holds the line low.
// RULE_04: reset line is always active low; no polarity option exists.
// RULE_05: powered device resets on line low or chip enable high; outputs float.
// RULE_06: serial-only variant releases on core threshold alone after the delay.
// RULE_07: parallel variant also waits for the I/O supply operating level.
// RULE_08: an external supervisor may hold the line low; device tolerates it.
// RULE_09: without clock output enabled, an external clock drives the target.
// RULE_10: busy input used only on parallel variant for fast byte mode.
// RULE_11: supply crossings are synchronous inputs; delay is a cycle counter.
`timescale 1ns/1ps
`default_nettype none
`include "cprs_map.svh"

module cprs_sequencer #(
    // variant select and release delay in clock cycles
    parameter bit PARALLEL_VARIANT = 1'b1,
    parameter logic [`CPRS_CNT_W-1:0] RELEASE_CYCLES = `CPRS_CNT_W'(`CPRS_RELEASE_CYCLES)
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // supply monitor
    input wire cprs_pkg::cprs_supply_t supply_i,
    // control pins
    input wire cprs_pkg::cprs_ctrl_t ctrl_i,
    input wire logic clk_out_enable_i,
    // shared open-drain reset/output-enable line
    input wire logic reset_oe_n_i,
    output logic reset_oe_n_o,
    output logic reset_oe_n_oe_o,
    // outputs toward target and chain
    output logic cascade_enable_out_n_o,
    output logic data_oe_o,
    output logic config_clock_out_oe_o,
    output logic [`CPRS_ADDR_W-1:0] addr_o
);

    // sequencer state
    cprs_pkg::cprs_state_t state_ff, nxt_state;
    logic [`CPRS_CNT_W-1:0] cnt_ff, nxt_cnt;
    // output stage registers
    logic hold_ff, nxt_hold;
    logic ceo_n_ff, nxt_ceo_n;
    logic data_oe_ff, nxt_data_oe;
    logic config_clock_out_oe_ff, nxt_config_clock_out_oe;
    logic [`CPRS_ADDR_W-1:0] addr_ff;
    // data level of the open-drain line, parked low in a register
    logic line_drv_ff;
    // address path
    logic [`CPRS_ADDR_W-1:0] cnt_addr;
    logic at_end;
    // decoded conditions
    logic supplies_ok;
    logic dev_reset;
    logic step;

    // true while the machine has not reached the running state
    function automatic logic fn_held(input cprs_pkg::cprs_state_t st);
        logic held;
        held = (st != cprs_pkg::CPRS_ST_RUN);
        return held;
    endfunction

    // release condition per variant
    function automatic logic fn_supplies_ok(input cprs_pkg::cprs_supply_t sup);
        logic ok;
        // RULE_06 core only
        // serial variant ignores the io flag entirely
        ok = sup.core_por_ok;
        // RULE_07 core and io
        if (PARALLEL_VARIANT) begin
            ok = sup.core_por_ok && sup.io_level_ok;
        end
        return ok;
    endfunction

    // RULE_11 monitor flags, already synchronous
    // a flag that drops during the delay restarts the count from zero,
    // so a supply bouncing around its threshold never releases early
    always_comb begin
        supplies_ok = fn_supplies_ok(supply_i);
    end

    // power sequencing state machine
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            cprs_pkg::CPRS_ST_HOLD: begin
                // counter parked at zero so every release waits a full delay
                nxt_cnt = `CPRS_CNT_ZERO;
                if (supplies_ok) begin
                    nxt_state = cprs_pkg::CPRS_ST_DELAY;
                end
            end
            cprs_pkg::CPRS_ST_DELAY: begin
                // RULE_02 release delay count
                // leaves after exactly RELEASE_CYCLES cycles in this state
                if (!supplies_ok) begin
                    nxt_state = cprs_pkg::CPRS_ST_HOLD;
                end else if (cnt_ff >= RELEASE_CYCLES - `CPRS_CNT_ONE) begin
                    nxt_state = cprs_pkg::CPRS_ST_RUN;
                end else begin
                    nxt_cnt = cnt_ff + `CPRS_CNT_ONE;
                end
            end
            cprs_pkg::CPRS_ST_RUN: begin
                // supplies lost while running fall straight back to hold
                if (!supplies_ok) begin
                    nxt_state = cprs_pkg::CPRS_ST_HOLD;
                end
            end
            // an illegal code recovers to the safe hold state
            default: begin
                nxt_state = cprs_pkg::CPRS_ST_HOLD;
            end
        endcase
        // RULE_03 power-down reset
        // power-down overrides every state and the release flags,
        // and the line stays held until core_above_pd returns and a full delay has passed
        if (!supply_i.core_above_pd) begin
            nxt_state = cprs_pkg::CPRS_ST_HOLD;
            nxt_cnt = `CPRS_CNT_ZERO;
        end
    end

    // sequencer registers
    // clock enable low freezes the state and the delay count together
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= cprs_pkg::CPRS_ST_HOLD;
            cnt_ff <= `CPRS_CNT_ZERO;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // RULE_01 hold line low
    // taken from the next state so the line moves on the same edge as the state
    always_comb begin
        nxt_hold = fn_held(nxt_state);
    end

    // RULE_05 functional reset, line sampled low-active only
    // RULE_04 fixed polarity
    // RULE_08 external hold acts as reset
    // the resolved line is read back, so a supervisor or the target pulling
    // it low clears the address just like the device's own hold
    assign dev_reset = fn_held(state_ff) || !reset_oe_n_i
                       || ctrl_i.chip_enable_n;

    // RULE_10 busy stalls the counter only on parallel variant
    // a stalled byte keeps its address until the target drops busy
    assign step = ctrl_i.clk_step && !(PARALLEL_VARIANT && ctrl_i.busy);

    // address counter, clear dominates so a reset cycle never also steps
    // terminal count stops the counter; it never wraps back to zero
    // its register is the address that the output stage decodes
    cprs_addr_counter u_addr (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .clear_i(dev_reset),
        .step_i(step && !dev_reset),
        .addr_o(cnt_addr),
        .at_end_o(at_end)
    );

    // output stage next values
    always_comb begin
        // defaults are the reset and standby values
        // RULE_05 floated outputs in reset
        nxt_ceo_n = 1'b1;
        nxt_data_oe = 1'b0;
        nxt_config_clock_out_oe = 1'b0;
        if (!dev_reset) begin
            // at terminal count data and clock float and the chain takes over
            nxt_ceo_n = !at_end;
            nxt_data_oe = !at_end;
            // RULE_09 clock output only when enabled
            nxt_config_clock_out_oe = clk_out_enable_i && !at_end;
        end
    end

    // output registers
    // addr_o lags the counter by one cycle so that it leaves a flop
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hold_ff <= 1'b1;
            ceo_n_ff <= 1'b1;
            data_oe_ff <= 1'b0;
            config_clock_out_oe_ff <= 1'b0;
            addr_ff <= `CPRS_ADDR_ZERO;
            line_drv_ff <= 1'b0;
        end else if (ce_i) begin
            line_drv_ff <= 1'b0;
            hold_ff <= nxt_hold;
            ceo_n_ff <= nxt_ceo_n;
            data_oe_ff <= nxt_data_oe;
            config_clock_out_oe_ff <= nxt_config_clock_out_oe;
            addr_ff <= cnt_addr;
        end
    end

    // open drain: drive low only, enable high pulls the line low
    // the enable, not the data, carries the hold
    assign reset_oe_n_o = line_drv_ff;
    assign reset_oe_n_oe_o = hold_ff;
    assign cascade_enable_out_n_o = ceo_n_ff;
    assign data_oe_o = data_oe_ff;
    assign config_clock_out_oe_o = config_clock_out_oe_ff;
    assign addr_o = addr_ff;

endmodule

`default_nettype wire

//--- verif/cprs_fpga_model.sv
`timescale 1ns/1ps
`default_nettype none
module cprs_fpga_model (
    // clock and line
    input wire logic clk_i,
    input wire logic line_i,
    input wire logic en_i,
    input wire logic hold_i,
    // toward device
    output logic step_o,
    output logic busy_o,
    output logic hold_n_o
);
    initial {step_o, busy_o} = 2'h0;
    always @(posedge clk_i) begin
        step_o <= #1 en_i && line_i && 1'($urandom);
        busy_o <= #1 en_i && 1'($urandom);
    end
    assign hold_n_o = !hold_i;
endmodule
`default_nettype wire

//--- verif/cprs_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "cprs_map.svh"
module cprs_seq_asserts #(
    parameter logic [`CPRS_CNT_W-1:0] RELEASE_CYCLES = 16'h64
) (
    // watched ports
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire cprs_pkg::cprs_supply_t supply_i,
    input wire cprs_pkg::cprs_ctrl_t ctrl_i,
    input wire logic reset_oe_n_i,
    input wire logic reset_oe_n_oe_o,
    input wire logic cascade_enable_out_n_o,
    input wire logic data_oe_o,
    input wire logic [`CPRS_ADDR_W-1:0] addr_o
);
    logic [15:0] ok_ff, nxt_ok;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i || !ce_i);
    // counts cycles with all supplies good
    always_comb nxt_ok = (reset_i || !(&supply_i)) ? 16'h0 : ok_ff + 16'h1;
    always_ff @(posedge clk_i) ok_ff <= nxt_ok;
    por_hold_a: assert property (!supply_i.core_por_ok |=> reset_oe_n_oe_o)
        else $error("por");
    release_wait_a: assert property ($fell(reset_oe_n_oe_o) |-> ok_ff >= RELEASE_CYCLES)
        else $error("early");
    pd_hold_a: assert property (!supply_i.core_above_pd |=> reset_oe_n_oe_o)
        else $error("pd");
    io_hold_a: assert property (!supply_i.io_level_ok |=> reset_oe_n_oe_o)
        else $error("io");
    line_off_a: assert property (!reset_oe_n_i |=> !data_oe_o)
        else $error("line");
    ce_high_a: assert property (ctrl_i.chip_enable_n |=> cascade_enable_out_n_o && !data_oe_o)
        else $error("ce");
    addr_clear_a: assert property (ctrl_i.chip_enable_n [*2] |=> addr_o == 20'h0)
        else $error("clr");
    busy_stall_a: assert property (ctrl_i.busy && !ctrl_i.chip_enable_n && reset_oe_n_i
        |-> ##2 $stable(addr_o)) else $error("busy");
endmodule
`default_nettype wire

//--- verif/test_config_prom_reset_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_config_prom_reset_sequencer;
    logic clk_i = 1'h0, rst = 1'h1, cen = 1'h1, en = 1'h0, hold = 1'h0, ck = 1'h0, pk = 1'h0;
    logic ce = 1'h1;
    cprs_pkg::cprs_supply_t sup = 3'h0;
    localparam int REL = 3;
    wire logic step, busy, hold_n, oe, doe, cascade_enable_out_n, cko, rdat;
    wire logic [19:0] addr;
    // open-drain line with pull-up: driven data when enabled, else pulled high
    wire logic line = (oe ? rdat : 1'h1) && hold_n;
    int fail_count = 0, compares = 0, n;
    logic [19:0] ea = 20'h0;
    cprs_fpga_model fpga (.clk_i, .line_i(line), .en_i(en), .hold_i(hold), .step_o(step),
        .busy_o(busy), .hold_n_o(hold_n));
    cprs_sequencer #(.RELEASE_CYCLES(16'(REL))) uut (.clk_i, .reset_i(rst), .ce_i(ce),
        .supply_i(sup), .ctrl_i({cen, busy, step}), .clk_out_enable_i(ck), .reset_oe_n_i(line),
        .reset_oe_n_o(rdat), .reset_oe_n_oe_o(oe), .cascade_enable_out_n_o(cascade_enable_out_n),
        .data_oe_o(doe), .config_clock_out_oe_o(cko), .addr_o(addr));
    initial forever #5 clk_i = ~clk_i;
    task automatic chk(input logic [19:0] s, input logic [19:0] e, input string w);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s exp %h seen %h", w, e, s);
        end
    endtask
    task automatic tk(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    // edges from the first good supply sample to release: entry plus the delay
    function automatic logic [19:0] exp_edges(input int rc);
        return 20'(rc + 1);
    endfunction
    // a byte advances only on a clock step that the target does not stall
    function automatic logic [19:0] exp_step(input logic s, input logic b);
        return 20'(s && !b);
    endfunction
    // supplies good, count edges until release
    task automatic rel();
        sup = 3'h7;
        for (n = 0; oe !== 1'h0 && n < 50; n++) tk(1);
        chk(20'(n), exp_edges(REL), "delay");
    endtask
    task automatic stop_test();
        $display("fail_count %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        void'($urandom(56));
        tk(20);
        rst = 1'h0;
        tk(5);
        chk(line, 1'h0, "por");
        chk(rdat, 1'h0, "drive");
        chk(doe, 1'h0, "rdoe");
        chk(cascade_enable_out_n, 1'h1, "rceo");
        chk(cko, 1'h0, "rcko");
        chk(addr, 20'h0, "raddr");
        sup = 3'h5;
        tk(10);
        chk(line, 1'h0, "io");
        rel();
        cen = 1'h0;
        tk(3);
        chk(doe, 1'h1, "run");
        for (int i = 0; i < 302; i++) begin
            en = (i < 300);
            @(negedge clk_i);
            ea += exp_step(step, busy);
            chk(cko, pk, "config_clock_out");
            tk(1);
            pk = ck;
            ck = 1'($urandom);
        end
        tk(2);
        chk(addr, ea, "count");
        cen = 1'h1;
        tk(3);
        chk(addr, 20'h0, "clr");
        chk(cascade_enable_out_n, 1'h1, "ceo");
        chk(cko, 1'h0, "sbcko");
        chk(doe, 1'h0, "sbdoe");
        cen = 1'h0;
        hold = 1'h1;
        tk(2);
        chk(doe, 1'h0, "hold");
        hold = 1'h0;
        tk(3);
        chk(doe, 1'h1, "back");
        sup = 3'h6;
        tk(1);
        chk(oe, 1'h1, "pd");
        // clock enable low freezes the machine in hold
        ce = 1'h0;
        sup = 3'h7;
        tk(10);
        chk(oe, 1'h1, "freeze");
        ce = 1'h1;
        rel();
        // reset in mid-run returns to hold with the line low
        rst = 1'h1;
        tk(2);
        chk(oe, 1'h1, "mrst");
        chk(doe, 1'h0, "mdoe");
        rst = 1'h0;
        rel();
        stop_test();
    end
endmodule
bind cprs_sequencer cprs_seq_asserts #(.RELEASE_CYCLES(RELEASE_CYCLES)) chk_i (.clk_i,
    .reset_i, .ce_i, .supply_i, .ctrl_i, .reset_oe_n_i, .reset_oe_n_oe_o,
    .cascade_enable_out_n_o, .data_oe_o, .addr_o);
`default_nettype wire
